// [gearbox_pkg.sv]
// Shared constants and carrier types for the output gearbox serializer.
package gearbox_pkg;

    localparam int WORD_W = 8;
    localparam int CNT_W = 3;
    localparam int SYNC_STAGES = 3;
    localparam int BUF_DEPTH = 2;

    localparam logic [CNT_W-1:0] VIDEO_LEN = 3'h7;
    localparam logic [CNT_W-1:0] EIGHT_LEN = 3'h0;
    localparam logic [CNT_W-1:0] FOUR_LEN = 3'h4;
    localparam logic [CNT_W-1:0] VIDEO_LAST = 3'h6;
    localparam logic [CNT_W-1:0] EIGHT_LAST = 3'h7;
    localparam logic [CNT_W-1:0] FOUR_LAST = 3'h3;

    localparam int FIRST_LANE_LSB = 0;
    localparam int THIRD_LANE_LSB = 4;

    localparam logic [WORD_W-1:0] VIDEO_MASK = 8'h7F;
    localparam logic [WORD_W-1:0] EIGHT_MASK = 8'hFF;
    localparam logic [WORD_W-1:0] FOUR_MASK = 8'hFF;

    localparam logic IDLE_LEVEL = 1'h0;
    localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;
    localparam logic [SYNC_STAGES-1:0] SYNC_RESET = 3'h0;

    typedef enum logic [2:0] {
        MODE_VIDEO = 3'b001,
        MODE_EIGHT = 3'b010,
        MODE_FOUR = 3'b100
    } gear_mode_t;

    typedef enum logic [1:0] {
        PIN_BLANK = 2'b01,
        PIN_USER = 2'b10
    } pin_state_t;

    typedef struct packed {
        logic data;
        logic oe;
        logic pull_up;
        logic pull_down;
    } pad_ctrl_t;

    localparam pad_ctrl_t PAD_BLANK_DOWN = '{data: 1'h0, oe: 1'h0, pull_up: 1'h0, pull_down: 1'h1};
    localparam pad_ctrl_t PAD_BLANK_UP = '{data: 1'h0, oe: 1'h0, pull_up: 1'h1, pull_down: 1'h0};

endpackage : gearbox_pkg

// [word_buffer.sv]
// Two-entry valid/ready buffer that holds parallel words from the core.
module word_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    generate
        if (DEPTH != 2 || WIDTH < 1) begin : g_bad_param
            $error("word_buffer supports exactly two entries of nonzero width.");
        end
    endgenerate

    logic [WIDTH-1:0] mem_reg [0:1];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= 1'h0;
            rd_ptr_reg <= 1'h0;
            count_reg <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            case ({push, pop})
                2'b10: count_reg <= count_reg + 2'h1;
                2'b01: count_reg <= count_reg - 2'h1;
                default: count_reg <= count_reg;
            endcase
        end
    end

endmodule : word_buffer

// [output_gearbox_serializer.sv]
// Output gearbox: parallel core words serialized onto one or two fast output lanes.
module output_gearbox_serializer #(
    parameter int WORD_W = gearbox_pkg::WORD_W
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Configuration.
    input wire logic config_loaded,
    input gearbox_pkg::gear_mode_t mode_sel,
    // Parallel words from the core.
    input wire logic core_valid,
    output logic core_ready,
    input wire logic [WORD_W-1:0] core_data,
    // Serial output pins.
    output gearbox_pkg::pad_ctrl_t first_lane_pad,
    output gearbox_pkg::pad_ctrl_t third_lane_pad,
    // Dedicated pins default state.
    output gearbox_pkg::pad_ctrl_t program_request_pin,
    output gearbox_pkg::pad_ctrl_t test_port_pad,
    // Status.
    output logic pins_configured,
    output logic serial_active
);

    // Each check guards a value that the logic below writes out by hand; any other value would send wrong bits.
    generate
        if (WORD_W != 8) begin : g_bad_width
            $error("output_gearbox_serializer serves an eight-bit parallel word only.");
        end

        if (gearbox_pkg::SYNC_STAGES != 3) begin : g_bad_sync
            $error("output_gearbox_serializer needs a three-flop configuration synchroniser.");
        end

        if (gearbox_pkg::CNT_W != 3) begin : g_bad_count
            $error("output_gearbox_serializer needs a three-bit serial counter.");
        end

        // A zero count marks the last bit, which is what lets the next word load with no gap.
        if (gearbox_pkg::CNT_RESET != 3'h0) begin : g_bad_count_reset
            $error("output_gearbox_serializer needs a zero idle count.");
        end

        if (gearbox_pkg::VIDEO_LAST != 3'h6) begin : g_bad_video_len
            $error("output_gearbox_serializer sends seven bits per video word.");
        end

        if (gearbox_pkg::EIGHT_LAST != 3'h7) begin : g_bad_eight_len
            $error("output_gearbox_serializer sends eight bits per eight-to-one word.");
        end

        if (gearbox_pkg::FOUR_LAST != 3'h3) begin : g_bad_four_len
            $error("output_gearbox_serializer sends four bits per lane in dual mode.");
        end

        if (gearbox_pkg::FIRST_LANE_LSB != 0) begin : g_bad_first_lane
            $error("output_gearbox_serializer starts the first lane at bit zero.");
        end

        // The dual shifter splits the word at its middle, so the third lane must start there.
        if (gearbox_pkg::THIRD_LANE_LSB != 4) begin : g_bad_third_lane
            $error("output_gearbox_serializer starts the third lane at bit four.");
        end

        if (gearbox_pkg::VIDEO_MASK != 8'h7F) begin : g_bad_video_mask
            $error("output_gearbox_serializer drops the top bit of a video word.");
        end

        if (gearbox_pkg::EIGHT_MASK != 8'hFF) begin : g_bad_eight_mask
            $error("output_gearbox_serializer keeps every bit of an eight-to-one word.");
        end

        if (gearbox_pkg::FOUR_MASK != 8'hFF) begin : g_bad_four_mask
            $error("output_gearbox_serializer keeps every bit of a dual word.");
        end

        if (gearbox_pkg::BUF_DEPTH != 2) begin : g_bad_depth
            $error("output_gearbox_serializer uses a two-entry stage-one buffer.");
        end

        if (gearbox_pkg::IDLE_LEVEL != 1'h0) begin : g_bad_idle
            $error("output_gearbox_serializer idles low to match the blank pull-down.");
        end
    endgenerate

    // Configuration-done synchroniser and pin state.
    logic [gearbox_pkg::SYNC_STAGES-1:0] cfg_sync_reg;
    logic cfg_done_reg;
    gearbox_pkg::pin_state_t pin_state_reg;
    gearbox_pkg::pin_state_t pin_state_next;
    gearbox_pkg::gear_mode_t mode_reg;
    logic user_mode;

    // Stage one: buffered capture of the core word.
    logic buf_in_valid;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    logic [WORD_W-1:0] buf_out_data;

    // Stage two: transfer register feeding the shifter.
    logic [WORD_W-1:0] xfer_word_reg;
    logic xfer_valid_reg;
    logic [WORD_W-1:0] lane_mask;

    // Stage three: shifter.
    logic [WORD_W-1:0] shift_reg;
    logic [WORD_W-1:0] shift_next;
    logic [gearbox_pkg::CNT_W-1:0] cnt_reg;
    logic [gearbox_pkg::CNT_W-1:0] last_count;
    logic active_reg;
    logic take_word;

    // The configuration flag comes from outside this clock; a change is believed once the last two stages agree.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_sync_reg <= gearbox_pkg::SYNC_RESET;
        end else begin
            cfg_sync_reg <= {cfg_sync_reg[1:0], config_loaded};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_done_reg <= 1'h0;
        end else if (cfg_sync_reg[1] == cfg_sync_reg[2]) begin
            cfg_done_reg <= cfg_sync_reg[2];
        end
    end

    // Pins leave the blank state only after reset has released and configuration is present.
    always_comb begin
        pin_state_next = pin_state_reg;
        case (pin_state_reg)
            gearbox_pkg::PIN_BLANK: begin
                if (cfg_done_reg) begin
                    pin_state_next = gearbox_pkg::PIN_USER;
                end
            end
            gearbox_pkg::PIN_USER: begin
                if (!cfg_done_reg) begin
                    pin_state_next = gearbox_pkg::PIN_BLANK;
                end
            end
            default: pin_state_next = gearbox_pkg::PIN_BLANK;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_state_reg <= gearbox_pkg::PIN_BLANK;
        end else begin
            pin_state_reg <= pin_state_next;
        end
    end

    assign user_mode = (pin_state_reg == gearbox_pkg::PIN_USER);

    // The mode is sampled once on entry to user state; changing it mid-stream would split words across modes.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg <= gearbox_pkg::MODE_EIGHT;
        end else if (pin_state_reg == gearbox_pkg::PIN_BLANK && pin_state_next == gearbox_pkg::PIN_USER) begin
            case (mode_sel)
                gearbox_pkg::MODE_VIDEO: mode_reg <= gearbox_pkg::MODE_VIDEO;
                gearbox_pkg::MODE_FOUR: mode_reg <= gearbox_pkg::MODE_FOUR;
                default: mode_reg <= gearbox_pkg::MODE_EIGHT;
            endcase
        end
    end

    // Bit field used by each mode and the length of one serial word.
    always_comb begin
        case (mode_reg)
            gearbox_pkg::MODE_VIDEO: begin
                lane_mask = gearbox_pkg::VIDEO_MASK;
                last_count = gearbox_pkg::VIDEO_LAST;
            end
            gearbox_pkg::MODE_FOUR: begin
                lane_mask = gearbox_pkg::FOUR_MASK;
                last_count = gearbox_pkg::FOUR_LAST;
            end
            default: begin
                lane_mask = gearbox_pkg::EIGHT_MASK;
                last_count = gearbox_pkg::EIGHT_LAST;
            end
        endcase
    end

    // Words are refused until the pins are in user state.
    assign buf_in_valid = core_valid && user_mode;
    assign core_ready = buf_in_ready && user_mode;

    word_buffer #(
        .WIDTH(WORD_W),
        .DEPTH(gearbox_pkg::BUF_DEPTH)
    ) u_stage_one (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(core_data),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    // The shifter takes a new word when idle or on the last bit of the current one, so words run back to back.
    assign take_word = xfer_valid_reg && user_mode && (!active_reg || cnt_reg == gearbox_pkg::CNT_RESET);
    assign buf_out_ready = !xfer_valid_reg || take_word;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            xfer_word_reg <= gearbox_pkg::WORD_RESET;
            xfer_valid_reg <= 1'h0;
        end else if (buf_out_valid && buf_out_ready) begin
            xfer_word_reg <= buf_out_data & lane_mask;
            xfer_valid_reg <= 1'h1;
        end else if (take_word) begin
            xfer_valid_reg <= 1'h0;
        end
    end

    // In dual four-to-one mode each nibble shifts on its own so the two lanes stay independent.
    always_comb begin
        if (mode_reg == gearbox_pkg::MODE_FOUR) begin
            shift_next = {1'h0, shift_reg[7:5], 1'h0, shift_reg[3:1]};
        end else begin
            shift_next = {1'h0, shift_reg[7:1]};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_reg <= gearbox_pkg::WORD_RESET;
            cnt_reg <= gearbox_pkg::CNT_RESET;
            active_reg <= 1'h0;
        end else if (take_word) begin
            shift_reg <= xfer_word_reg;
            cnt_reg <= last_count;
            active_reg <= 1'h1;
        end else if (active_reg && cnt_reg != gearbox_pkg::CNT_RESET) begin
            shift_reg <= shift_next;
            cnt_reg <= cnt_reg - 3'h1;
        end else begin
            shift_reg <= gearbox_pkg::WORD_RESET;
            cnt_reg <= gearbox_pkg::CNT_RESET;
            active_reg <= 1'h0;
        end
    end

    // Pad drive comes from flops so the serial bit has one clean launch edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            first_lane_pad <= gearbox_pkg::PAD_BLANK_DOWN;
        end else if (user_mode) begin
            first_lane_pad.data <= active_reg ? shift_reg[gearbox_pkg::FIRST_LANE_LSB] : gearbox_pkg::IDLE_LEVEL;
            first_lane_pad.oe <= 1'h1;
            first_lane_pad.pull_up <= 1'h0;
            first_lane_pad.pull_down <= 1'h0;
        end else begin
            first_lane_pad <= gearbox_pkg::PAD_BLANK_DOWN;
        end
    end

    // The third lane is only a separate output in dual four-to-one mode; otherwise it stays blank.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            third_lane_pad <= gearbox_pkg::PAD_BLANK_DOWN;
        end else if (user_mode && mode_reg == gearbox_pkg::MODE_FOUR) begin
            third_lane_pad.data <= active_reg ? shift_reg[gearbox_pkg::THIRD_LANE_LSB] : gearbox_pkg::IDLE_LEVEL;
            third_lane_pad.oe <= 1'h1;
            third_lane_pad.pull_up <= 1'h0;
            third_lane_pad.pull_down <= 1'h0;
        end else begin
            third_lane_pad <= gearbox_pkg::PAD_BLANK_DOWN;
        end
    end

    // Dedicated pins keep a weak pull-up while blank and stay undriven with that pull-up in user state as well.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            program_request_pin <= gearbox_pkg::PAD_BLANK_UP;
            test_port_pad <= gearbox_pkg::PAD_BLANK_UP;
        end else begin
            program_request_pin.data <= 1'h0;
            program_request_pin.oe <= 1'h0;
            program_request_pin.pull_up <= 1'h1;
            program_request_pin.pull_down <= 1'h0;
            test_port_pad.data <= 1'h0;
            test_port_pad.oe <= 1'h0;
            test_port_pad.pull_up <= 1'h1;
            test_port_pad.pull_down <= 1'h0;
        end
    end

    assign pins_configured = user_mode;
    assign serial_active = active_reg;

endmodule : output_gearbox_serializer

// [gearbox_chk.sv]
// Concurrent checks on the ports of the output gearbox serializer.
module gearbox_chk (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Core side.
    input wire logic config_loaded,
    input gearbox_pkg::gear_mode_t mode_sel,
    input wire logic core_valid,
    input wire logic core_ready,
    // Pins and status.
    input gearbox_pkg::pad_ctrl_t first_lane_pad,
    input gearbox_pkg::pad_ctrl_t third_lane_pad,
    input gearbox_pkg::pad_ctrl_t program_request_pin,
    input gearbox_pkg::pad_ctrl_t test_port_pad,
    input wire logic pins_configured,
    input wire logic serial_active
);
    logic take;
    assign take = core_valid && core_ready;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // The pad flops lag the state flop by one cycle, so pad checks need two samples in one state.
    sequence blank2_s;
        !pins_configured ##1 !pins_configured;
    endsequence
    sequence user2_s;
        pins_configured ##1 pins_configured;
    endsequence
    ready_blank_a: assert property (!pins_configured |-> !core_ready)
        else $error("Core ready while pins blank.");
    blank_pad_a: assert property (blank2_s |-> first_lane_pad == gearbox_pkg::PAD_BLANK_DOWN)
        else $error("Lane pad not blank pull-down.");
    dedicated_pull_a: assert property (program_request_pin == gearbox_pkg::PAD_BLANK_UP && test_port_pad == gearbox_pkg::PAD_BLANK_UP)
        else $error("Dedicated pin not pull-up.");
    user_drive_a: assert property (user2_s |-> first_lane_pad.oe && !first_lane_pad.pull_up && !first_lane_pad.pull_down)
        else $error("Configured lane not driven.");
    idle_level_a: assert property (!serial_active |=> first_lane_pad.data == gearbox_pkg::IDLE_LEVEL && third_lane_pad.data == gearbox_pkg::IDLE_LEVEL)
        else $error("Lane not idle without a word.");
    third_mode_a: assert property (third_lane_pad.oe |-> mode_sel == gearbox_pkg::MODE_FOUR)
        else $error("Third lane driven outside dual mode.");
    cfg_rise_a: assert property ($rose(pins_configured) |-> $past(config_loaded) && $past(config_loaded, 2))
        else $error("Pins configured without configuration.");
    start_delay_a: assert property ($rose(serial_active) |-> $past(take, 3))
        else $error("Shifter start not three stages after take.");
endmodule : gearbox_chk

bind output_gearbox_serializer gearbox_chk gearbox_chk_i (.clk(clk), .rst_b(rst_b), .config_loaded(config_loaded),
    .mode_sel(mode_sel), .core_valid(core_valid), .core_ready(core_ready), .first_lane_pad(first_lane_pad),
    .third_lane_pad(third_lane_pad), .program_request_pin(program_request_pin), .test_port_pad(test_port_pad),
    .pins_configured(pins_configured), .serial_active(serial_active));

// [serial_rx.sv]
// Behavioural serial receiver that records the bits seen on one output lane.
module serial_rx (
    // Clock.
    input wire logic clk,
    // Lane pad.
    input gearbox_pkg::pad_ctrl_t pad,
    // Line level and bit history, newest bit at the top.
    output logic line,
    output logic [31:0] hist
);
    logic last;
    // A released line settles to its weak pull; with none it shows the inverse of the last bit.
    assign line = pad.oe ? pad.data : pad.pull_up ? 1'h1 : pad.pull_down ? 1'h0 : ~last;
    always_ff @(posedge clk) begin
        last <= line;
        hist <= {line, hist[31:1]};
    end
endmodule : serial_rx

// [tb.sv]
// Self-checking testbench for the output gearbox serializer.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, config_loaded, core_valid, core_ready, pins_configured, serial_active, refused;
    logic first_line, third_line;
    logic [7:0] core_data;
    logic [31:0] first_hist, third_hist;
    gearbox_pkg::gear_mode_t mode_sel;
    gearbox_pkg::pad_ctrl_t first_lane_pad, third_lane_pad, program_request_pin, test_port_pad;
    int n_mismatch, comparisons;
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    output_gearbox_serializer output_gearbox_serializer_i (.clk(clk), .rst_b(rst_b), .config_loaded(config_loaded),
        .mode_sel(mode_sel), .core_valid(core_valid), .core_ready(core_ready), .core_data(core_data),
        .first_lane_pad(first_lane_pad), .third_lane_pad(third_lane_pad), .program_request_pin(program_request_pin),
        .test_port_pad(test_port_pad), .pins_configured(pins_configured), .serial_active(serial_active));
    serial_rx first_rx (.clk(clk), .pad(first_lane_pad), .line(first_line), .hist(first_hist));
    serial_rx third_rx (.clk(clk), .pad(third_lane_pad), .line(third_line), .hist(third_hist));
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task timeout(input string what);
        n_mismatch++;
        $display("[ERR] %s expected handshake seen none", what);
        summarize();
    endtask : timeout
    // Every scenario restarts from reset because the mode is sampled only when the pins leave the blank state.
    task start(input gearbox_pkg::gear_mode_t m, input logic cfg);
        int i;
        @(negedge clk);
        rst_b = 1'h0;
        core_valid = 1'h0;
        mode_sel = m;
        config_loaded = cfg;
        repeat (6) @(negedge clk);
        check("reset ready", 1'h0, core_ready);
        check("reset active", 1'h0, serial_active);
        check("reset pad", gearbox_pkg::PAD_BLANK_DOWN, first_lane_pad);
        rst_b = 1'h1;
        for (i = 0; i < 20 && cfg && pins_configured !== 1'h1; i++) @(negedge clk);
        if (i == 20) timeout("configure");
        @(negedge clk);
    endtask : start
    task send(input logic [7:0] d);
        int i;
        core_data = d;
        core_valid = 1'h1;
        for (i = 0; i < 50 && core_ready !== 1'h1; i++) begin
            refused = 1'h1;
            @(negedge clk);
        end
        if (i == 50) timeout("send");
        @(negedge clk);
    endtask : send
    task drain;
        int i;
        core_valid = 1'h0;
        for (i = 0; i < 10 && serial_active !== 1'h1; i++) @(negedge clk);
        if (i == 10) timeout("drain start");
        for (i = 0; i < 80 && serial_active !== 1'h0; i++) @(negedge clk);
        if (i == 80) timeout("drain");
        @(negedge clk);
    endtask : drain
    task test_blank;
        start(gearbox_pkg::MODE_EIGHT, 1'h0);
        repeat (10) @(negedge clk);
        check("blank configured", 1'h0, pins_configured);
        check("blank ready", 1'h0, core_ready);
        check("blank line", 1'h0, first_line);
        check("request pin", gearbox_pkg::PAD_BLANK_UP, program_request_pin);
        check("test pad", gearbox_pkg::PAD_BLANK_UP, test_port_pad);
        config_loaded = 1'h1;
        repeat (8) @(negedge clk);
        check("user configured", 1'h1, pins_configured);
        check("user oe", 1'h1, first_lane_pad.oe);
        config_loaded = 1'h0;
        repeat (8) @(negedge clk);
        check("back to blank", gearbox_pkg::PAD_BLANK_DOWN, first_lane_pad);
        $display("test_blank done");
    endtask : test_blank
    task test_eight;
        start(gearbox_pkg::MODE_EIGHT, 1'h1);
        send(8'hA5);
        core_valid = 1'h0;
        @(negedge clk);
        check("active after one", 1'h0, serial_active);
        @(negedge clk);
        check("active after two", 1'h1, serial_active);
        drain();
        check("eight word", 8'hA5, first_hist[31:24]);
        check("third lane unused", gearbox_pkg::PAD_BLANK_DOWN, third_lane_pad);
        $display("test_eight done");
    endtask : test_eight
    task test_video;
        start(gearbox_pkg::MODE_VIDEO, 1'h1);
        send(8'hD3);
        drain();
        check("video word", 7'h53, first_hist[31:25]);
        check("video idle after", 1'h0, first_line);
        $display("test_video done");
    endtask : test_video
    task test_dual;
        start(gearbox_pkg::MODE_FOUR, 1'h1);
        send(8'h3C);
        drain();
        check("first lane nibble", 4'hC, first_hist[31:28]);
        check("third lane nibble", 4'h3, third_hist[31:28]);
        $display("test_dual done");
    endtask : test_dual
    task test_burst;
        start(gearbox_pkg::MODE_EIGHT, 1'h1);
        refused = 1'h0;
        send(8'h11);
        send(8'hE2);
        send(8'h4B);
        send(8'h96);
        send(8'h7C);
        drain();
        check("burst refused", 1'h1, refused);
        check("burst stream", 32'h7C964BE2, first_hist);
        $display("test_burst done");
    endtask : test_burst
    task test_reset_mid;
        start(gearbox_pkg::MODE_EIGHT, 1'h1);
        send(8'hFF);
        core_valid = 1'h0;
        repeat (5) @(negedge clk);
        start(gearbox_pkg::MODE_EIGHT, 1'h1);
        send(8'h81);
        drain();
        check("word after reset", 8'h81, first_hist[31:24]);
        $display("test_reset_mid done");
    endtask : test_reset_mid
    initial begin
        n_mismatch = 0;
        comparisons = 0;
        rst_b = 1'h0;
        config_loaded = 1'h0;
        mode_sel = gearbox_pkg::MODE_EIGHT;
        core_valid = 1'h0;
        core_data = 8'h00;
        refused = 1'h0;
        test_blank();
        test_eight();
        test_video();
        test_dual();
        test_burst();
        test_reset_mid();
        summarize();
    end
endmodule : tb
